// [rtl/evs_status_top.sv]
// Summary of operation
// [RULE1] A clear-status command empties the event register, the status byte summary and the error queue; an event bit set in the same cycle stays set.
// [RULE2] An enable bit at one lets the event in the same position reach the summary.
// [RULE3] The summary bit of the status byte is the OR of all enabled event bits.
// [RULE4] Reading the event register returns its value and then clears it entirely; an event bit set in the same cycle as the read stays set.
// [RULE5] Event register and enable mask share one layout: 0 done, 2 query, 3 device, 4 execution, 5 command, 7 power-on.
// [RULE6] The power-on bit (bit 7) is one after every power-up.
// [RULE7] The operation-complete command clears the operation-complete bit.
// [RULE8] After that command the bit returns to one once all earlier commands have finished.
// [RULE9] The reset command restores all settings to their factory defaults; here it only pulses defaults_restore_o for one cycle.
// [RULE10] The identification query returns one comma-separated string of maker, model, serial and firmware.
// [RULE11] Status byte bits do not latch; each follows its source.
// [RULE12] Event bits stay set until a read of the register or a clear-status command; bit 0 also clears on the operation-complete command.
module evs_status_top #(
  parameter int unsigned ERR_CNT_W = evs_pkg::ERR_CNT_W
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          cmd_cls_i,
  input  wire logic                          cmd_ena_wr_i,
  input  wire logic [7:0]                    cmd_ena_data_i,
  input  wire logic                          cmd_ena_rd_i,
  input  wire logic                          cmd_evt_rd_i,
  input  wire logic                          cmd_stb_rd_i,
  input  wire logic                          cmd_id_rd_i,
  input  wire logic [evs_pkg::ID_ADDR_W-1:0] cmd_id_addr_i,
  input  wire logic                          cmd_opc_i,
  input  wire logic                          cmd_rst_i,
  input  wire logic                          busy_i,
  input  wire logic                          evt_query_err_i,
  input  wire logic                          evt_dev_err_i,
  input  wire logic                          evt_exec_err_i,
  input  wire logic                          evt_cmd_err_i,
  input  wire logic                          err_pop_i,
  input  wire logic                          quest_i,
  input  wire logic                          msg_avail_i,
  output logic      [7:0]                    rd_data_o,
  output logic                               rd_valid_o,
  output logic      [7:0]                    status_byte_o,
  output logic                               evt_summary_o,
  output logic      [ERR_CNT_W-1:0]          err_count_o,
  output logic                               defaults_restore_o
);

  logic [7:0]           evt_val;
  logic [7:0]           evt_set;
  logic [7:0]           evt_clr;
  logic [7:0]           ena_q;
  logic [7:0]           ena_d;
  logic                 opc_pend_q;
  logic                 opc_pend_d;
  logic                 opc_done_set;
  logic                 summary;
  logic [7:0]           stb_q;
  logic [7:0]           stb_d;
  logic [ERR_CNT_W-1:0] err_cnt_q;
  logic [ERR_CNT_W-1:0] err_cnt_d;
  logic                 err_push;
  logic                 err_full;
  logic                 err_empty;
  logic [7:0]           rd_data_q;
  logic [7:0]           rd_data_d;
  logic                 rd_valid_q;
  logic                 any_rd;
  logic                 rst_pulse_q;
  logic [7:0]           id_data;
  evs_pkg::evs_rd_e     rd_sel_q;
  evs_pkg::evs_rd_e     rd_sel_d;

  // event sources in register layout
  assign evt_set[evs_pkg::BIT_OP_DONE]   = opc_done_set;   // see [RULE8]
  assign evt_set[1]                      = 1'b0;
  assign evt_set[evs_pkg::BIT_QUERY_ERR] = evt_query_err_i; // see [RULE5]
  assign evt_set[evs_pkg::BIT_DEV_ERR]   = evt_dev_err_i;
  assign evt_set[evs_pkg::BIT_EXEC_ERR]  = evt_exec_err_i;
  assign evt_set[evs_pkg::BIT_CMD_ERR]   = evt_cmd_err_i;
  assign evt_set[6]                      = 1'b0;
  assign evt_set[evs_pkg::BIT_POWER_ON]  = 1'b0;

  // read and clear-status wipe the whole register
  assign evt_clr[evs_pkg::BIT_OP_DONE] = cmd_cls_i | cmd_evt_rd_i | cmd_opc_i; // see [RULE7]
  assign evt_clr[7:1] = {7{cmd_cls_i | cmd_evt_rd_i}}; // see [RULE4]

  // sticky event bits; power-on bit comes out of reset at one
  for (genvar i = 0; i < 8; i++) begin : g_evt
    evs_sticky_bit #(
      .RST_VAL (evs_pkg::EVT_RST_VAL[i])
    ) u_bit (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .set_i      (evt_set[i]),
      .clr_i      (evt_clr[i]),
      .q_o        (evt_val[i])
    ); // see [RULE12] see [RULE6]
  end

  // operation-complete tracking
  assign opc_pend_d   = cmd_opc_i | (opc_pend_q & busy_i);
  assign opc_done_set = opc_pend_q & ~busy_i & ~cmd_opc_i; // see [RULE8]

  // enable mask, unused bits held at zero
  assign ena_d = cmd_ena_wr_i ? (cmd_ena_data_i & evs_pkg::EVT_USED_MASK) : ena_q;

  // summary and status byte follow their sources
  assign summary = |(evt_val & ena_q); // see [RULE2] see [RULE3]

  always_comb begin
    stb_d                         = 8'h00;
    stb_d[evs_pkg::STB_QUEST_BIT] = quest_i;
    stb_d[evs_pkg::STB_MSG_BIT]   = msg_avail_i;
    stb_d[evs_pkg::STB_SUM_BIT]   = summary; // see [RULE11]
  end

  // error queue depth
  assign err_push  = evt_query_err_i | evt_dev_err_i | evt_exec_err_i | evt_cmd_err_i;
  assign err_full  = &err_cnt_q;
  assign err_empty = (err_cnt_q == '0);
  assign err_cnt_d = cmd_cls_i                        ? '0 :                       // see [RULE1]
                     (err_push & ~err_pop_i & ~err_full) ? err_cnt_q + 1'b1 :
                     (err_pop_i & ~err_push & ~err_empty) ? err_cnt_q - 1'b1 :
                     err_cnt_q;

  // read path
  assign any_rd   = cmd_ena_rd_i | cmd_evt_rd_i | cmd_stb_rd_i | cmd_id_rd_i;
  assign rd_sel_d = cmd_evt_rd_i ? evs_pkg::EVS_RD_EVT :
                    cmd_ena_rd_i ? evs_pkg::EVS_RD_ENA :
                    cmd_stb_rd_i ? evs_pkg::EVS_RD_STB :
                    cmd_id_rd_i  ? evs_pkg::EVS_RD_ID  : evs_pkg::EVS_RD_NONE;

  always_comb begin
    case (rd_sel_d)
      evs_pkg::EVS_RD_EVT: rd_data_d = evt_val; // see [RULE4]
      evs_pkg::EVS_RD_ENA: rd_data_d = ena_q;
      evs_pkg::EVS_RD_STB: rd_data_d = stb_q;
      default:             rd_data_d = 8'h00;
    endcase
  end

  evs_id_rom u_id_rom (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .rd_i       (cmd_id_rd_i),
    .addr_i     (cmd_id_addr_i),
    .data_o     (id_data)
  ); // see [RULE10]

  assign rd_data_o          = (rd_sel_q == evs_pkg::EVS_RD_ID) ? id_data : rd_data_q;
  assign rd_valid_o         = rd_valid_q;
  assign status_byte_o      = stb_q;
  assign evt_summary_o      = stb_q[evs_pkg::STB_SUM_BIT];
  assign err_count_o        = err_cnt_q;
  assign defaults_restore_o = rst_pulse_q; // see [RULE9]

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ena_q      <= evs_pkg::ENA_RST_VAL;
      opc_pend_q <= 1'b0;
      stb_q      <= evs_pkg::STB_RST_VAL;
      err_cnt_q  <= '0;
    end else begin
      ena_q      <= ena_d;
      opc_pend_q <= opc_pend_d;
      stb_q      <= stb_d;
      err_cnt_q  <= err_cnt_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_q   <= 8'h00;
      rd_valid_q  <= 1'b0;
      rd_sel_q    <= evs_pkg::EVS_RD_NONE;
      rst_pulse_q <= 1'b0;
    end else begin
      rd_data_q   <= rd_data_d;
      rd_valid_q  <= any_rd;
      rd_sel_q    <= rd_sel_d;
      rst_pulse_q <= cmd_rst_i;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  clear_status_a: assert property ( // see [RULE1]
    cmd_cls_i |=> ((evt_val & ~$past(evt_set)) == 8'h00) && (err_cnt_q == '0))
    else $error("clear status left event bits or error count");

  enable_gate_a: assert property ( // see [RULE2]
    (ena_q == 8'h00) |=> !stb_q[evs_pkg::STB_SUM_BIT])
    else $error("summary set with empty enable mask");

  summary_or_a: assert property ( // see [RULE3]
    ##1 (stb_q[evs_pkg::STB_SUM_BIT] == $past(|(evt_val & ena_q))))
    else $error("summary bit differs from enabled events");

  read_clear_a: assert property ( // see [RULE4]
    (cmd_evt_rd_i && !cmd_ena_rd_i && evt_set == 8'h00)
      |=> rd_valid_o && (rd_data_o == $past(evt_val)) && (evt_val == 8'h00))
    else $error("event read did not return then clear");

  unused_zero_a: assert property ( // see [RULE5]
    ((evt_val | ena_q) & ~evs_pkg::EVT_USED_MASK) == 8'h00)
    else $error("unused event or enable bit set");

  opc_clear_a: assert property ( // see [RULE7]
    (cmd_opc_i && !opc_done_set) |=> !evt_val[evs_pkg::BIT_OP_DONE])
    else $error("operation complete bit not cleared");

  opc_return_a: assert property ( // see [RULE8]
    (opc_pend_q && !busy_i && !cmd_opc_i) |=> evt_val[evs_pkg::BIT_OP_DONE] && !opc_pend_q)
    else $error("operation complete bit not restored when idle");

  opc_wait_a: assert property ( // see [RULE8]
    (opc_pend_q && busy_i && !cmd_opc_i && !cmd_cls_i && !cmd_evt_rd_i)
      |=> opc_pend_q && !$changed(evt_val[evs_pkg::BIT_OP_DONE]))
    else $error("operation complete set while busy");

  restore_pulse_a: assert property ( // see [RULE9]
    cmd_rst_i |=> defaults_restore_o ##1 (defaults_restore_o == $past(cmd_rst_i)))
    else $error("factory restore pulse wrong");

  stb_follow_a: assert property ( // see [RULE11]
    $fell(msg_avail_i) |=> !status_byte_o[evs_pkg::STB_MSG_BIT])
    else $error("status byte bit latched");

  event_hold_a: assert property ( // see [RULE12]
    (evt_val[evs_pkg::BIT_CMD_ERR] && !cmd_cls_i && !cmd_evt_rd_i)
      |=> evt_val[evs_pkg::BIT_CMD_ERR])
    else $error("event bit dropped without clear");

  power_on_a: assert property ( // see [RULE6]
    $fell(rst_i) |-> evt_val[evs_pkg::BIT_POWER_ON])
    else $error("power-on bit not set after reset");

  cls_summary_a: assert property ( // see [RULE1]
    (cmd_cls_i && (evt_set == 8'h00)) |=> ##1 !status_byte_o[evs_pkg::STB_SUM_BIT])
    else $error("summary still set after clear status");

  err_count_up_a: assert property ( // see [RULE1]
    (err_push && !err_pop_i && !err_full && !cmd_cls_i)
      |=> (err_cnt_q == $past(err_cnt_q) + 1'b1))
    else $error("error count did not step up");

  err_count_down_a: assert property ( // see [RULE1]
    (err_pop_i && !err_push && !err_empty && !cmd_cls_i)
      |=> (err_cnt_q == $past(err_cnt_q) - 1'b1))
    else $error("error count did not step down");

  err_count_sat_a: assert property ( // see [RULE1]
    (err_full && !err_pop_i && !cmd_cls_i) |=> err_full)
    else $error("error count left its ceiling");

  read_valid_a: assert property ( // see [RULE4]
    ##1 (rd_valid_o == $past(any_rd)))
    else $error("read valid not one cycle after read");

  mask_write_a: assert property ( // see [RULE5]
    cmd_ena_wr_i
      |=> (ena_q == ($past(cmd_ena_data_i) & evs_pkg::EVT_USED_MASK)))
    else $error("enable mask write not taken");

  mask_read_a: assert property ( // see [RULE2]
    (cmd_ena_rd_i && !cmd_evt_rd_i) |=> (rd_data_o == $past(ena_q)))
    else $error("enable mask read wrong");

  stb_read_a: assert property ( // see [RULE11]
    (cmd_stb_rd_i && !cmd_evt_rd_i && !cmd_ena_rd_i) |=> (rd_data_o == $past(stb_q)))
    else $error("status byte read wrong");

  stb_spare_a: assert property ( // see [RULE11]
    (status_byte_o & 8'hC7) == 8'h00)
    else $error("spare status byte bit set");

  quest_follow_a: assert property ( // see [RULE11]
    ##1 (status_byte_o[evs_pkg::STB_QUEST_BIT] == $past(quest_i)))
    else $error("questionable bit does not follow source");

  event_set_a: assert property ( // see [RULE12]
    ##1 ((evt_val & $past(evt_set)) == $past(evt_set)))
    else $error("event not latched");

  id_end_a: assert property ( // see [RULE10]
    (cmd_id_rd_i && !cmd_evt_rd_i && !cmd_ena_rd_i && !cmd_stb_rd_i
      && (32'(cmd_id_addr_i) >= evs_pkg::ID_LEN))
      |=> (rd_data_o == evs_pkg::ID_END_CHAR))
    else $error("identification end character wrong");

  opc_arm_a: assert property ( // see [RULE7]
    cmd_opc_i |=> opc_pend_q)
    else $error("operation complete not armed");

  restore_idle_a: assert property ( // see [RULE9]
    !cmd_rst_i |=> !defaults_restore_o)
    else $error("factory restore pulse without command");

  cov_read_clear_c:   cover property (evt_val[evs_pkg::BIT_EXEC_ERR] ##1 cmd_evt_rd_i);
  cov_opc_cycle_c:    cover property (cmd_opc_i ##1 busy_i [*3] ##1 !busy_i);
  cov_summary_c:      cover property ($rose(stb_q[evs_pkg::STB_SUM_BIT]));
  cov_set_over_clr_c: cover property (cmd_evt_rd_i && evt_cmd_err_i);
  cov_id_end_c:       cover property (cmd_id_rd_i && (32'(cmd_id_addr_i) >= evs_pkg::ID_LEN));

endmodule : evs_status_top

// [rtl/evs_pkg.sv]
package evs_pkg;

  // event register layout, shared by the enable mask
  localparam int unsigned EVT_W          = 8;
  localparam int unsigned BIT_OP_DONE    = 0;
  localparam int unsigned BIT_QUERY_ERR  = 2;
  localparam int unsigned BIT_DEV_ERR    = 3;
  localparam int unsigned BIT_EXEC_ERR   = 4;
  localparam int unsigned BIT_CMD_ERR    = 5;
  localparam int unsigned BIT_POWER_ON   = 7;

  // status byte layout
  localparam int unsigned STB_QUEST_BIT  = 3;
  localparam int unsigned STB_MSG_BIT    = 4;
  localparam int unsigned STB_SUM_BIT    = 5;

  // values after reset (power-up)
  localparam logic [7:0]  EVT_RST_VAL    = 8'h80;
  localparam logic [7:0]  ENA_RST_VAL    = 8'h00;
  localparam logic [7:0]  STB_RST_VAL    = 8'h00;
  localparam logic [7:0]  EVT_USED_MASK  = 8'hBD;

  // error queue depth counter
  localparam int unsigned ERR_CNT_W      = 4;

  // identification string: maker,model,serial,firmware (arbitrary values)
  localparam int unsigned ID_LEN         = 29;
  localparam int unsigned ID_ADDR_W      = 5;
  localparam logic [8*ID_LEN-1:0] ID_STR = "VENDORX,LOAD01,SN00001,FW0001";
  localparam logic [7:0]  ID_END_CHAR    = 8'h0A;

  // read source selection
  typedef enum logic [4:0] {
    EVS_RD_NONE = 5'b00001,
    EVS_RD_ENA  = 5'b00010,
    EVS_RD_EVT  = 5'b00100,
    EVS_RD_STB  = 5'b01000,
    EVS_RD_ID   = 5'b10000
  } evs_rd_e;

endpackage : evs_pkg

// [rtl/evs_sticky_bit.sv]
module evs_sticky_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      q_o
);

  logic q_q;
  logic q_d;

  // set wins over a clear in the same cycle
  assign q_d = set_i | (q_q & ~clr_i);
  assign q_o = q_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_q <= RST_VAL;
    end else begin
      q_q <= q_d;
    end
  end

endmodule : evs_sticky_bit

// [rtl/evs_id_rom.sv]
module evs_id_rom #(
  parameter int unsigned LEN    = evs_pkg::ID_LEN,
  parameter int unsigned ADDR_W = evs_pkg::ID_ADDR_W
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              rd_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic      [7:0]        data_o
);

  logic [7:0] data_q;
  logic [7:0] data_d;
  logic       in_range;

  // first character sits in the top byte of the string constant
  assign in_range = (32'(addr_i) < LEN);
  assign data_d   = in_range ? evs_pkg::ID_STR[8*(LEN-1-32'(addr_i)) +: 8]
                             : evs_pkg::ID_END_CHAR;
  assign data_o   = data_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_q <= 8'h00;
    end else if (rd_i) begin
      data_q <= data_d;
    end
  end

endmodule : evs_id_rom

// [bench/evs_host_model.sv]
module evs_host_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rd_data_i,
  output logic            cls_o,
  output logic            ena_wr_o,
  output logic            ena_rd_o,
  output logic            evt_rd_o,
  output logic            stb_rd_o,
  output logic            id_rd_o,
  output logic            opc_o,
  output logic            rst_cmd_o,
  output logic      [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] strobe_q = 8'h00;
  logic [7:0] data_q   = 8'h00;

  // one strobe per kind: 0 clear, 1 mask write, 2 mask read, 3 event read,
  // 4 status read, 5 id read, 6 operation complete, 7 factory reset
  assign cls_o     = strobe_q[0];
  assign ena_wr_o  = strobe_q[1];
  assign ena_rd_o  = strobe_q[2];
  assign evt_rd_o  = strobe_q[3];
  assign stb_rd_o  = strobe_q[4];
  assign id_rd_o   = strobe_q[5];
  assign opc_o     = strobe_q[6];
  assign rst_cmd_o = strobe_q[7];
  assign data_o    = data_q;

  // strobe stands for one edge, answer taken once settled
  task automatic send(input int k, input logic [7:0] a, output logic [7:0] got);
    @(posedge core_clk_i);
    strobe_q <= 8'h01 << k;
    data_q   <= a;
    @(posedge core_clk_i);
    strobe_q <= 8'h00;
    #1 got = rd_data_i;
  endtask : send

endmodule : evs_host_model

// [bench/tb_event_status_reporting.sv]
module tb_event_status_reporting;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        busy       = 1'b0;
  logic        pop        = 1'b0;
  logic        quest      = 1'b0;
  logic        msg        = 1'b0;
  logic [3:0]  ev         = 4'h0;
  logic        cls, ewr, erd, vrd, srd, ird, opc, rcmd, rdv, sum, dflt;
  logic [7:0]  wdat, rdat, sb, v, mask, exp_evt, exp_sb;
  logic [3:0]  ecnt;
  logic [31:0] seed       = 32'h0000_2060;
  int          num_errors  = 0;
  int          check_count = 0;
  int          cyc         = 0;
  int          commas;

  evs_host_model host (
    .core_clk_i(core_clk_i), .rd_data_i(rdat), .cls_o(cls), .ena_wr_o(ewr), .ena_rd_o(erd),
    .evt_rd_o(vrd), .stb_rd_o(srd), .id_rd_o(ird), .opc_o(opc), .rst_cmd_o(rcmd),
    .data_o(wdat)
  );

  evs_status_top uut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_cls_i(cls), .cmd_ena_wr_i(ewr),
    .cmd_ena_data_i(wdat), .cmd_ena_rd_i(erd), .cmd_evt_rd_i(vrd), .cmd_stb_rd_i(srd),
    .cmd_id_rd_i(ird), .cmd_id_addr_i(wdat[4:0]), .cmd_opc_i(opc), .cmd_rst_i(rcmd),
    .busy_i(busy), .evt_query_err_i(ev[0]), .evt_dev_err_i(ev[1]), .evt_exec_err_i(ev[2]),
    .evt_cmd_err_i(ev[3]), .err_pop_i(pop), .quest_i(quest), .msg_avail_i(msg),
    .rd_data_o(rdat), .rd_valid_o(rdv), .status_byte_o(sb), .evt_summary_o(sum),
    .err_count_o(ecnt), .defaults_restore_o(dflt)
  );

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // event inputs query, device, execution, command land on bits 2..5
  function automatic logic [7:0] ev_bits(input logic [3:0] e);
    return {2'b00, e, 2'b00};
  endfunction : ev_bits

  function automatic logic [7:0] stb_exp(input logic [7:0] m, input logic [7:0] evt);
    return {2'b00, |(m & evt), 5'h00};
  endfunction : stb_exp

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input int k, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] got;
    host.send(k, a, got);
    chk(got, e);
    chk({7'h00, rdv}, 8'h01);
  endtask : rd

  task automatic pulse_ev(input logic [3:0] e);
    @(posedge core_clk_i);
    ev <= e;
    @(posedge core_clk_i);
    ev <= 4'h0;
  endtask : pulse_ev

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(3, 8'h00, 8'h80);
    rd(3, 8'h00, 8'h00);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      mask = (i == 0) ? 8'hFF : seed[7:0];
      host.send(1, mask, v);
      rd(2, 8'h00, mask & evs_pkg::EVT_USED_MASK);
      mask = mask & evs_pkg::EVT_USED_MASK;
      exp_evt = ev_bits(seed[11:8]);
      exp_sb = stb_exp(mask, exp_evt);
      pulse_ev(seed[11:8]);
      repeat (3) @(posedge core_clk_i);
      #1 chk(sb, exp_sb);
      chk({7'h00, sum}, {7'h00, exp_sb[5]});
      rd(3, 8'h00, exp_evt);
    end
    // operation complete waits for earlier commands
    host.send(1, 8'h01, v);
    @(posedge core_clk_i) busy <= 1'b1;
    host.send(6, 8'h00, v);
    repeat (4) @(posedge core_clk_i);
    #1 chk({7'h00, sum}, 8'h00);
    @(posedge core_clk_i) busy <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1 chk({7'h00, sum}, 8'h01);
    @(posedge core_clk_i) busy <= 1'b1;
    host.send(6, 8'h00, v);
    repeat (3) @(posedge core_clk_i);
    #1 chk({7'h00, sum}, 8'h00);
    rd(3, 8'h00, 8'h00);
    @(posedge core_clk_i) busy <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rd(3, 8'h00, 8'h01);
    // error queue fills to its ceiling, then clear-status empties all
    for (int i = 0; i < 17; i++) begin
      pulse_ev(4'h8);
    end
    repeat (2) @(posedge core_clk_i);
    #1 chk({4'h0, ecnt}, 8'h0F);
    @(posedge core_clk_i) pop <= 1'b1;
    @(posedge core_clk_i) pop <= 1'b0;
    @(posedge core_clk_i);
    #1 chk({4'h0, ecnt}, 8'h0E);
    host.send(1, 8'h20, v);
    repeat (2) @(posedge core_clk_i);
    #1 chk({7'h00, sum}, 8'h01);
    host.send(0, 8'h00, v);
    repeat (2) @(posedge core_clk_i);
    #1 chk({4'h0, ecnt}, 8'h00);
    chk(sb, 8'h00);
    rd(3, 8'h00, 8'h00);
    // status byte follows its sources
    @(posedge core_clk_i);
    quest <= 1'b1;
    msg <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 chk(sb, 8'h18);
    rd(4, 8'h00, 8'h18);
    @(posedge core_clk_i) quest <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 chk(sb, 8'h10);
    host.send(7, 8'h00, v);
    chk({7'h00, dflt}, 8'h01);
    @(posedge core_clk_i);
    #1 chk({7'h00, dflt}, 8'h00);
    commas = 0;
    for (int i = 0; i < 30; i++) begin
      host.send(5, 8'(i), v);
      if (i < 29 && v === 8'h2C) begin
        commas++;
      end
    end
    chk(v, 8'h0A);
    chk(8'(commas), 8'h03);
    // second power-up in mid-run
    @(posedge core_clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(3, 8'h00, 8'h80);
    rd(2, 8'h00, 8'h00);
    close_out();
  end
endmodule : tb_event_status_reporting
